// ===== logic/charger_regs_pkg.sv
package charger_regs_pkg;

  // Register offsets
  localparam logic [7:0] FAULT_STATUS_OFS = 8'h09;
  localparam logic [7:0] REG_STATUS_OFS   = 8'h0a;
  localparam logic [7:0] PART_INFO_OFS    = 8'h0b;

  // Fault register field positions
  localparam int WDOG_BIT  = 7;
  localparam int BOOST_BIT = 6;
  localparam int CHG_HI    = 5;
  localparam int CHG_LO    = 4;
  localparam int BATOV_BIT = 3;
  localparam int THERM_HI  = 2;
  localparam int THERM_LO  = 0;

  // Regulation status field positions
  localparam int IN_GOOD_BIT  = 7;
  localparam int VLIM_BIT     = 6;
  localparam int ILIM_BIT     = 5;
  localparam int RSENSE_BIT   = 4;
  localparam int TOPOFF_BIT   = 3;
  localparam int INOV_BIT     = 2;
  localparam int VMASK_BIT    = 1;
  localparam int IMASK_BIT    = 0;

  // Part information field positions and values
  localparam int         SOFT_RST_BIT  = 7;
  localparam logic [3:0] PART_CODE     = 4'h3;   // Arbitrary value
  localparam logic [2:0] PART_RESERVED = 3'h4;

  // Charge fault codes
  localparam logic [1:0] CHG_NORMAL  = 2'h0;
  localparam logic [1:0] CHG_INPUT   = 2'h1;
  localparam logic [1:0] CHG_THERMAL = 2'h2;
  localparam logic [1:0] CHG_TIMER   = 2'h3;

  // Thermistor fault codes
  localparam logic [2:0] THERM_NORMAL = 3'h0;
  localparam logic [2:0] THERM_WARM   = 3'h2;
  localparam logic [2:0] THERM_COOL   = 3'h3;
  localparam logic [2:0] THERM_COLD   = 3'h5;
  localparam logic [2:0] THERM_HOT    = 3'h6;

  // Reset values
  localparam logic       WDOG_RESET = 1'b1;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Serial link
  localparam logic [6:0] DEV_ADDR = 7'h2a;       // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Interrupt pulse width
  localparam int CLK_MHZ      = 100;
  localparam int INT_PULSE_US = 256;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;

  // Number of analog status inputs
  localparam int NUM_STAT = 18;

endpackage

// ===== logic/serial_link_slave.sv
`timescale 1ns/100ps
`default_nettype none
module serial_link_slave
  import charger_regs_pkg::*;
(
  // Link clock and core reset
  input  wire logic        link_clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Register write event to the core
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             wr_tgl,
  // Register snapshot from the core
  input  wire logic [23:0] snap_c,
  input  wire logic        snap_ack_tgl,
  output logic             snap_req_tgl
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b011,
    ST_RX    = 3'b010,
    ST_TX    = 3'b110,
    ST_TXACK = 3'b111
  } link_state_e;

  logic [1:0]  rst_sync_r;
  logic        lrst;
  logic [2:0]  scl_r;
  logic [2:0]  sda_r;
  logic [1:0]  ack_sync_r;
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;
  link_state_e state_r;
  logic [7:0]  sh_r;
  logic [3:0]  cnt_r;
  logic        rw_r;
  logic        first_r;
  logic [7:0]  ptr_r;
  logic [23:0] snap_r;
  logic [7:0]  rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisers
  always_ff @(posedge link_clk) begin
    rst_sync_r <= {rst_sync_r[0], rst};
    scl_r      <= {scl_r[1:0], scl_i};
    sda_r      <= {sda_r[1:0], sda_i};
    ack_sync_r <= {ack_sync_r[0], snap_ack_tgl};
  end

  assign lrst    = rst_sync_r[1];
  assign rise    = scl_r[1] & ~scl_r[2];
  assign fall    = ~scl_r[1] & scl_r[2];
  assign start_c = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
  assign stop_c  = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot handshake: copy when the core has answered, then ask again
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      snap_req_tgl <= 1'b0;
      snap_r       <= 24'h0;
    end else if (ack_sync_r[1] == snap_req_tgl) begin
      snap_r       <= snap_c;
      snap_req_tgl <= ~snap_req_tgl;
    end
  end

  // Read data by pointer; unmapped reads return zero
  always_comb begin
    unique case (ptr_r)
      FAULT_STATUS_OFS: rd_byte = snap_r[23:16];
      REG_STATUS_OFS:   rd_byte = snap_r[15:8];
      PART_INFO_OFS:    rd_byte = snap_r[7:0];
      default:          rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte protocol engine
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      state_r <= ST_IDLE;
      sh_r    <= 8'h00;
      cnt_r   <= 4'h0;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      ptr_r   <= 8'h00;
      sda_oe  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_tgl  <= 1'b0;
    end else if (start_c) begin
      state_r <= ST_ADDR;
      cnt_r   <= 4'h0;
      first_r <= 1'b1;
      sda_oe  <= 1'b0;
    end else if (stop_c) begin
      state_r <= ST_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR: begin
          if (rise) begin
            sh_r  <= {sh_r[6:0], sda_r[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (fall && cnt_r == BITS_PER_BYTE) begin
            cnt_r <= 4'h0;
            if (sh_r[7:1] == DEV_ADDR) begin
              rw_r    <= sh_r[0];
              sda_oe  <= 1'b1;                 // Acknowledge own address
              state_r <= ST_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            if (rw_r) begin
              sda_oe  <= ~rd_byte[7];
              sh_r    <= {rd_byte[6:0], 1'b0};
              cnt_r   <= 4'h1;
              state_r <= ST_TX;
            end else begin
              sda_oe  <= 1'b0;
              cnt_r   <= 4'h0;
              state_r <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            sh_r  <= {sh_r[6:0], sda_r[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (fall && cnt_r == BITS_PER_BYTE) begin
            if (first_r) begin
              ptr_r   <= sh_r;                 // First byte sets the pointer
              first_r <= 1'b0;
            end else begin
              wr_addr <= ptr_r;
              wr_data <= sh_r;
              wr_tgl  <= ~wr_tgl;
              ptr_r   <= ptr_r + 8'h01;
            end
            sda_oe  <= 1'b1;
            state_r <= ST_ACK;
          end
        end
        ST_TX: begin
          if (fall) begin
            if (cnt_r == BITS_PER_BYTE) begin
              sda_oe  <= 1'b0;
              ptr_r   <= ptr_r + 8'h01;
              state_r <= ST_TXACK;
            end else begin
              sda_oe <= ~sh_r[7];
              sh_r   <= {sh_r[6:0], 1'b0};
              cnt_r  <= cnt_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (rise) begin
            state_r <= sda_r[1] ? ST_IDLE : ST_ACK;  // Stop sending on a nack
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // The pin is only ever pulled low
  always_ff @(posedge link_clk) begin
    sda_o <= 1'b0;
  end

endmodule
`default_nettype wire

// ===== logic/charger_status_regs.sv
// Functional notes
// - Watchdog flag bit 7, powers up set
// - Boost fault flag bit 6
// - Charge fault 00 normal, 01 input, 10 thermal, 11 timer
// - Battery overvoltage flag bit 3
// - Buck thermistor codes normal/warm/cool/cold/hot
// - Boost thermistor codes only normal/cold/hot
// - Input good flag bit 7
// - Input voltage limit flag bit 6
// - Input current limit flag bit 5
// - Remote sense fault flag bit 4
// - Top-off counting flag bit 3
// - Input overvoltage flag bit 2
// - Bit 1 masks voltage limit interrupt pulse
// - Bit 0 masks current limit interrupt pulse
// - Soft reset bit restores the interrupt mask defaults, self clears
`timescale 1ns/100ps
`default_nettype none
module charger_status_regs
  import charger_regs_pkg::*;
#(
  parameter int INT_PULSE_CYCLES = INT_PULSE_CYC
)
(
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Serial link
  input  wire logic link_clk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Analog status inputs
  input  wire logic watchdog_expired,
  input  wire logic otg_output_overload,
  input  wire logic otg_low_battery,
  input  wire logic input_fault,
  input  wire logic thermal_shutdown,
  input  wire logic safety_timer_expired,
  input  wire logic battery_overvoltage,
  input  wire logic boost_mode,
  input  wire logic therm_warm,
  input  wire logic therm_cool,
  input  wire logic therm_cold,
  input  wire logic therm_hot,
  input  wire logic input_good,
  input  wire logic input_voltage_regulation,
  input  wire logic input_current_regulation,
  input  wire logic remote_sense_open,
  input  wire logic topoff_counting,
  input  wire logic input_overvoltage,
  // Host interrupt and timer control
  output logic      int_n,
  output logic      safety_timer_rst
);

  logic [NUM_STAT-1:0] stat_m_r;
  logic [NUM_STAT-1:0] stat_q_r;
  logic [NUM_STAT-1:0] stat_raw;
  logic [7:0]          fault_r;
  logic [7:0]          fault_nxt;
  logic [5:0]          regstat_r;
  logic                voltage_limit_irq_mask_r;
  logic                current_limit_irq_mask_r;
  logic                soft_rst_r;
  logic [1:0]          charge_fault_code;
  logic [2:0]          thermistor_fault_code;
  logic [7:0]          wr_addr;
  logic [7:0]          wr_data;
  logic                wr_tgl;
  logic [2:0]          wr_sync_r;
  logic                wr_evt;
  logic                snap_req_tgl;
  logic [1:0]          req_sync_r;
  logic                snap_ack_r;
  logic [23:0]         snap_r;
  logic                vlim_d_r;
  logic                ilim_d_r;
  logic                irq_evt;
  logic [15:0]         pulse_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link side engine on its own clock
  serial_link_slave u_link (
    .link_clk     (link_clk),
    .rst          (rst),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .sda_o        (sda_o),
    .sda_oe       (sda_oe),
    .wr_addr      (wr_addr),
    .wr_data      (wr_data),
    .wr_tgl       (wr_tgl),
    .snap_c       (snap_r),
    .snap_ack_tgl (snap_ack_r),
    .snap_req_tgl (snap_req_tgl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the analog status levels
  assign stat_raw = {watchdog_expired, otg_output_overload, otg_low_battery,
                     input_fault, thermal_shutdown, safety_timer_expired,
                     battery_overvoltage, boost_mode, therm_warm, therm_cool,
                     therm_cold, therm_hot, input_good, input_voltage_regulation,
                     input_current_regulation, remote_sense_open,
                     topoff_counting, input_overvoltage};

  always_ff @(posedge core_clk) begin
    stat_m_r <= stat_raw;
    stat_q_r <= stat_m_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge fault encoding, most serious condition first
  always_comb begin
    if (stat_q_r[12]) begin
      charge_fault_code = CHG_TIMER;
    end else if (stat_q_r[13]) begin
      charge_fault_code = CHG_THERMAL;
    end else if (stat_q_r[14]) begin
      charge_fault_code = CHG_INPUT;
    end else begin
      charge_fault_code = CHG_NORMAL;
    end
  end

  // Thermistor encoding; warm and cool are hidden in boost mode
  always_comb begin
    if (stat_q_r[6]) begin
      thermistor_fault_code = THERM_HOT;
    end else if (stat_q_r[7]) begin
      thermistor_fault_code = THERM_COLD;
    end else if (stat_q_r[9] && !stat_q_r[10]) begin
      thermistor_fault_code = THERM_WARM;
    end else if (stat_q_r[8] && !stat_q_r[10]) begin
      thermistor_fault_code = THERM_COOL;
    end else begin
      thermistor_fault_code = THERM_NORMAL;
    end
  end

  // Fault register image
  always_comb begin
    fault_nxt                    = 8'h00;
    fault_nxt[WDOG_BIT]          = stat_q_r[17];
    fault_nxt[BOOST_BIT]         = stat_q_r[16] | stat_q_r[15];
    fault_nxt[CHG_HI:CHG_LO]     = charge_fault_code;
    fault_nxt[BATOV_BIT]         = stat_q_r[11];
    fault_nxt[THERM_HI:THERM_LO] = thermistor_fault_code;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status registers, watchdog flag set out of reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_r           <= 8'h00;
      fault_r[WDOG_BIT] <= WDOG_RESET;
      regstat_r         <= 6'h00;
    end else begin
      fault_r   <= fault_nxt;
      regstat_r <= stat_q_r[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write event crossing: toggle synchroniser plus edge detect
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_sync_r <= 3'h0;
    end else begin
      wr_sync_r <= {wr_sync_r[1:0], wr_tgl};
    end
  end

  assign wr_evt = wr_sync_r[2] ^ wr_sync_r[1];

  // Interrupt masks; soft reset restores them
  always_ff @(posedge core_clk) begin
    if (rst || soft_rst_r) begin
      voltage_limit_irq_mask_r <= MASK_RESET[VMASK_BIT];
      current_limit_irq_mask_r <= MASK_RESET[IMASK_BIT];
    end else if (wr_evt && wr_addr == REG_STATUS_OFS) begin
      voltage_limit_irq_mask_r <= wr_data[VMASK_BIT];
      current_limit_irq_mask_r <= wr_data[IMASK_BIT];
    end
  end

  // Soft reset bit: set by write, cleared once the reset is done
  always_ff @(posedge core_clk) begin
    if (rst) begin
      soft_rst_r <= 1'b0;
    end else if (soft_rst_r) begin
      soft_rst_r <= 1'b0;
    end else if (wr_evt && wr_addr == PART_INFO_OFS) begin
      soft_rst_r <= wr_data[SOFT_RST_BIT];
    end
  end

  // Safety timer reset pulse follows the soft reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      safety_timer_rst <= 1'b0;
    end else begin
      safety_timer_rst <= soft_rst_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot crossing: capture when a new request arrives
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_sync_r <= 2'h0;
    end else begin
      req_sync_r <= {req_sync_r[0], snap_req_tgl};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      snap_ack_r <= 1'b0;
      snap_r     <= 24'h0;
    end else if (req_sync_r[1] != snap_ack_r) begin
      snap_ack_r <= req_sync_r[1];
      snap_r     <= {fault_r,
                     regstat_r, voltage_limit_irq_mask_r, current_limit_irq_mask_r,
                     soft_rst_r, PART_CODE, PART_RESERVED};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulse on entry into regulation, unless masked
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vlim_d_r <= 1'b0;
      ilim_d_r <= 1'b0;
    end else begin
      vlim_d_r <= stat_q_r[4];
      ilim_d_r <= stat_q_r[3];
    end
  end

  assign irq_evt = (stat_q_r[4] & ~vlim_d_r & ~voltage_limit_irq_mask_r)
                 | (stat_q_r[3] & ~ilim_d_r & ~current_limit_irq_mask_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulse_cnt_r <= 16'h0000;
      int_n       <= 1'b1;
    end else if (irq_evt) begin
      pulse_cnt_r <= 16'(INT_PULSE_CYCLES - 1);
      int_n       <= 1'b0;
    end else if (pulse_cnt_r != 16'h0000) begin
      pulse_cnt_r <= pulse_cnt_r - 16'h0001;
    end else begin
      int_n <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/charger_status_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module charger_status_regs_assertions #(
  parameter int INT_PULSE_CYCLES = 20
)
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Regulation inputs and pulses
  input wire logic input_voltage_regulation,
  input wire logic input_current_regulation,
  input wire logic int_n,
  input wire logic safety_timer_rst
);
  logic [2:0]  since_r;
  logic [31:0] low_r;
  ////////////////////////////////////////
  // Cycles since a regulation entry, saturating
  always_ff @(posedge core_clk) begin
    if (rst)
      since_r <= 3'h7;
    else if ($rose(input_voltage_regulation) || $rose(input_current_regulation))
      since_r <= 3'h0;
    else if (since_r != 3'h7)
      since_r <= since_r + 3'h1;
  end
  // Length of the current interrupt pulse
  always_ff @(posedge core_clk) begin
    if (rst || int_n)
      low_r <= 32'h0;
    else
      low_r <= low_r + 32'h1;
  end
  ////////////////////////////////////////
  a_drive_low_only: assert property (
    @(posedge link_clk) disable iff (rst) sda_oe |-> !sda_o)
    else $error("data pin driven high");
  a_ack_low_phase: assert property (
    @(posedge link_clk) disable iff (rst) $rose(sda_oe) |-> !scl_i)
    else $error("data drive began in clock high phase");
  a_release_low_phase: assert property (
    @(posedge link_clk) disable iff (rst) $fell(sda_oe) |-> !scl_i)
    else $error("data drive ended in clock high phase");
  a_steady_while_high: assert property (
    @(posedge link_clk) disable iff (rst) scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  a_int_has_cause: assert property (
    @(posedge core_clk) disable iff (rst) $fell(int_n) |-> since_r <= 3'h5)
    else $error("interrupt without regulation entry");
  a_int_min_hold: assert property (
    @(posedge core_clk) disable iff (rst) $fell(int_n) |=> !int_n [*8])
    else $error("interrupt pulse cut short");
  a_int_full_width: assert property (
    @(posedge core_clk) disable iff (rst) $rose(int_n) |-> low_r >= INT_PULSE_CYCLES)
    else $error("interrupt pulse too short");
  a_timer_rst_single: assert property (
    @(posedge core_clk) disable iff (rst) safety_timer_rst |=> !safety_timer_rst)
    else $error("timer reset longer than one cycle");
  // Main scenarios
  c_int_pulse: cover property (@(posedge core_clk) disable iff (rst) $fell(int_n));
  c_timer_rst: cover property (@(posedge core_clk) disable iff (rst) safety_timer_rst);
  c_ack: cover property (@(posedge link_clk) disable iff (rst) $rose(sda_oe));
endmodule
bind charger_status_regs charger_status_regs_assertions #(
  .INT_PULSE_CYCLES(INT_PULSE_CYCLES)
) i_chk (
  .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n), .safety_timer_rst(safety_timer_rst),
  .input_voltage_regulation(input_voltage_regulation),
  .input_current_regulation(input_current_regulation)
);
`default_nettype wire

// ===== testbench/host_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  // Serial pins
  output logic        scl_o,
  output logic        sda_pull,
  input  wire logic   sda_w,
  // Observed bytes with their ack bit
  output logic [8:0]  res_val,
  output logic [15:0] res_cnt
);
  // Idle bus: clock stands high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
    res_val = 9'h000;
    res_cnt = 16'h0000;
  end
  ////////////////////////////////////////
  // One bit: data set in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #120 sda_pull = !b;
    #360 scl_o = 1'b1;
    #380 r = sda_w;
    #20 scl_o = 1'b0;
  endtask
  task automatic frame_open;
    #120 sda_pull = 1'b0;
    #360 scl_o = 1'b1;
    #400 sda_pull = 1'b1;
    #400 scl_o = 1'b0;
  endtask
  task automatic frame_close;
    #120 sda_pull = 1'b1;
    #360 scl_o = 1'b1;
    #400 sda_pull = 1'b0;
    #400;
  endtask
  // Byte, msb first, then the ack bit; wire levels are reported
  task automatic xb(input logic [7:0] d, input logic a);
    logic [8:0] q;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i + 1]);
    bit_io(a, q[0]);
    res_val = {q[0], q[8:1]};
    res_cnt = res_cnt + 16'h0001;
  endtask
  ////////////////////////////////////////
  // Pointer then one data byte; a one in bit 7 of the part register resets
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d);
    frame_open();
    xb({dv, 1'b0}, 1'b1);
    xb(a, 1'b1);
    xb(d, 1'b1);
    frame_close();
  endtask
  // Pointer, repeated start, n bytes acked except the last
  task automatic rd(input logic [6:0] dv, input logic [7:0] a, input int n);
    frame_open();
    xb({dv, 1'b0}, 1'b1);
    xb(a, 1'b1);
    frame_open();
    xb({dv, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) xb(8'hff, k == n - 1);
    frame_close();
  endtask
endmodule
`default_nettype wire

// ===== testbench/charger_status_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module charger_status_regs_test
  import charger_regs_pkg::*;
;
  logic        core_clk;
  logic        link_clk;
  logic        rst;
  logic [17:0] st;
  logic        scl;
  logic        pull;
  logic        sda_o;
  logic        sda_oe;
  logic        int_n;
  logic        strst;
  logic [8:0]  res_val;
  logic [15:0] res_cnt;
  logic [31:0] seed = 32'h85aa893c;
  logic [3:0]  sel;
  logic [15:0] fx;
  logic [8:0]  exp_q[$];
  logic [4:0]  tt[8] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03, 5'h0d, 5'h13};
  logic [7:0]  pi = {1'b0, PART_CODE, PART_RESERVED};
  int          err_count = 0;
  int          checks_done = 0;
  int          falls = 0;
  int          pulses = 0;
  int          f0;
  wire         sda_w = !(pull | (sda_oe & !sda_o));
  ////////////////////////////////////////
  // Clocks, link clock unrelated in phase
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #40 link_clk = !link_clk;
  end
  charger_status_regs #(.INT_PULSE_CYCLES(20)) i_dut (
    .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .watchdog_expired(st[0]),
    .otg_output_overload(st[1]), .otg_low_battery(st[2]), .input_fault(st[3]),
    .thermal_shutdown(st[4]), .safety_timer_expired(st[5]), .battery_overvoltage(st[6]),
    .boost_mode(st[7]), .therm_warm(st[8]), .therm_cool(st[9]), .therm_cold(st[10]),
    .therm_hot(st[11]), .input_good(st[12]), .input_voltage_regulation(st[13]),
    .input_current_regulation(st[14]), .remote_sense_open(st[15]),
    .topoff_counting(st[16]), .input_overvoltage(st[17]), .int_n(int_n),
    .safety_timer_rst(strst)
  );
  host_link_model i_host (
    .scl_o(scl), .sda_pull(pull), .sda_w(sda_w), .res_val(res_val), .res_cnt(res_cnt)
  );
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Expected fault and regulation status bytes
  function automatic logic [7:0] ef(input logic [17:0] s);
    logic [1:0] c;
    logic [2:0] t;
    c = s[5] ? CHG_TIMER : s[4] ? CHG_THERMAL : s[3] ? CHG_INPUT : CHG_NORMAL;
    t = s[11] ? THERM_HOT : s[10] ? THERM_COLD : s[7] ? THERM_NORMAL :
        s[8] ? THERM_WARM : s[9] ? THERM_COOL : THERM_NORMAL;
    return {s[0], s[1] | s[2], c, s[6], t};
  endfunction
  function automatic logic [7:0] es(input logic [17:0] s, input logic [1:0] m);
    return {s[12], s[13], s[14], s[15], s[16], s[17], m};
  endfunction
  task automatic check_byte(input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t byte exp %h got %h", $time, e, g);
    end
  endtask
  task automatic check_cnt(input int e, input int g);
    checks_done++;
    if (g != e) begin
      err_count++;
      $display("BAD %0t count exp %0d got %0d", $time, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d);
    logic n;
    n = (dv != DEV_ADDR);
    exp_q.push_back({n, dv, 1'b0});
    exp_q.push_back({n, a});
    exp_q.push_back({n, d});
    i_host.wr(dv, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input int n, input logic [23:0] e);
    exp_q.push_back({1'b0, DEV_ADDR, 1'b0});
    exp_q.push_back({1'b0, a});
    exp_q.push_back({1'b0, DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) exp_q.push_back({k == n - 1, e[8 * k +: 8]});
    i_host.rd(DEV_ADDR, a, n);
  endtask
  task automatic pulse_reg(input logic [1:0] v);
    @(negedge core_clk);
    st[14:13] = v;
    repeat (100) @(negedge core_clk);
    st[14:13] = 2'h0;
    repeat (100) @(negedge core_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Result watchers
  always @(res_cnt) begin
    if (res_cnt != 16'h0000) begin
      if (exp_q.size() > 0)
        check_byte(exp_q.pop_front(), res_val);
      else
        check_byte(9'h000, 9'h1ff);
    end
  end
  always @(negedge int_n) falls++;
  always @(posedge core_clk) if (strst === 1'b1) pulses++;
  initial begin
    repeat (90000) @(posedge core_clk);
    check_cnt(0, 1);
    close_out();
  end
  // Main sequence
  initial begin
    st = 18'h00000;
    rst = 1'b1;
    repeat (40) @(negedge core_clk);
    rst = 1'b0;
    repeat (300) @(negedge core_clk);
    rd(REG_STATUS_OFS, 2, {8'h00, pi, 8'h00});
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      sel = 4'h1 << (i % 4);
      @(negedge core_clk);
      st = seed[17:0];
      st[5:3] = sel[3:1];
      st[11:7] = tt[i];
      repeat (300) @(negedge core_clk);
      fx[7:0] = ef(st);
      fx[15:8] = es(st, 2'h0);
      rd(FAULT_STATUS_OFS, 2, {8'h00, fx});
    end
    $display("status codes done");
    @(negedge core_clk);
    st = 18'h00001;
    wr(DEV_ADDR, REG_STATUS_OFS, 8'hff);
    wr(DEV_ADDR, PART_INFO_OFS, 8'h7f);
    wr(DEV_ADDR, FAULT_STATUS_OFS, 8'h00);
    rd(FAULT_STATUS_OFS, 3, {pi, 8'h03, 8'h80});
    f0 = falls;
    pulse_reg(2'h3);
    check_cnt(f0, falls);
    $display("masks done");
    wr(DEV_ADDR, PART_INFO_OFS, 8'h80);
    check_cnt(1, pulses);
    rd(REG_STATUS_OFS, 2, {8'h00, pi, 8'h00});
    pulse_reg(2'h1);
    check_cnt(f0 + 1, falls);
    pulse_reg(2'h2);
    check_cnt(f0 + 2, falls);
    $display("soft reset done");
    wr(DEV_ADDR ^ 7'h01, REG_STATUS_OFS, 8'h03);
    rd(REG_STATUS_OFS, 1, 24'h000000);
    rd(8'h20, 1, 24'h000000);
    check_cnt(0, exp_q.size());
    $display("refusals done");
    close_out();
  end
endmodule
`default_nettype wire
